// File: hdl/host_cmd_error_classifier.sv
// error detection and coding for the host command interface
`timescale 1ns/1ps
`default_nettype none
`include "hce_consts.svh"
module host_cmd_error_classifier
	import hce_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// mode
	input wire logic boot_mode_i,
	// flash access and startup events
	input wire flash_ev_s flash_i,
	input wire boot_ev_s boot_i,
	// command interpreter events
	input wire cmd_ev_s cmd_i,
	input wire logic q_full_i,
	// host link transactions and buffers
	input wire xfer_ev_s xfer_i,
	input wire buf_ev_s buf_i,
	// error record read
	input wire logic [`REC_AW-1:0] rec_idx_i,
	// error report
	output logic err_pulse_o,
	output logic [7:0] err_code_o,
	output logic [7:0] last_code_o,
	output logic [7:0] err_cnt_o,
	output logic [7:0] rec_data_o,
	output logic cmd_reject_o,
	output logic rd_pending_o
);
	cls_st_s st_r;
	cls_st_s st_nxt;
	logic [7:0] c;
	logic hit;
	logic do_clear;
	logic [16:0] full_len;
	logic [16:0] xcnt_nx;
	logic [15:0] pcnt_now;
	logic [16:0] xcnt_now;
	logic rec_we;
	logic [`REC_AW-1:0] rec_waddr;

	// conditions are checked lowest priority first, so later ones win;
	// only one code per cycle is recorded, the others of that cycle are lost
	always_comb begin
		st_nxt = st_r;
		c = 8'h00;
		hit = 1'b0;
		do_clear = 1'b0;
		full_len = 17'h0_0000;
		xcnt_nx = {1'b0, st_r.xcnt} + 17'h0_0001;
		xcnt_now = {1'b0, st_r.xcnt};
		pcnt_now = st_r.pcnt;
		rec_we = 1'b0;
		rec_waddr = st_r.wptr;
		// both pulses last a single cycle
		st_nxt.err = 1'b0;
		st_nxt.rej = 1'b0;

		// startup and image load
		// load crc stages
		if (boot_i.crc_verify) begin
			c = `E_VERIFY_CRC;
			hit = 1'b1;
		end
		if (boot_i.crc_ram) begin
			c = `E_MAIN_RAM_CRC;
			hit = 1'b1;
		end
		if (boot_i.crc_main) begin
			c = `E_MAIN_LOAD_CRC;
			hit = 1'b1;
		end
		if (boot_i.crc_boot) begin
			c = `E_BOOT_LOAD_CRC;
			hit = 1'b1;
		end
		if (boot_i.id_tmo) begin
			c = `E_FLASH_TMO;
			hit = 1'b1;
		end
		if (boot_i.id_done && !boot_i.id_ok) begin
			c = `E_ID_READ;
			hit = 1'b1;
		end
		if (boot_i.id_done && boot_i.id_ok && !boot_i.dev_found) begin
			c = `E_NO_DEVICE;
			hit = 1'b1;
		end
		if (boot_i.id_done && boot_i.id_ok && !boot_i.dev_known) begin
			c = `E_NO_DEVICE;
			hit = 1'b1;
		end

		// flash access
		if (flash_i.req) begin
			if (flash_i.op == FOP_WR && flash_i.size > `FLASH_CAP_BYTES) begin
				c = `E_OUT_OF_RANGE;
				hit = 1'b1;
			end
			if (flash_i.op == FOP_WR && !flash_i.erased) begin
				c = `E_WR_SEQ;
				hit = 1'b1;
			end
			if (flash_i.op != FOP_RD && !flash_i.present) begin
				c = `E_NO_DEVICE;
				hit = 1'b1;
			end
			if (flash_i.busy) begin
				c = `E_FLASH_BUSY;
				hit = 1'b1;
			end
		end
		// a timeout outranks whatever the request itself did
		// flash timeout, for any operation
		if (flash_i.tmo) begin
			c = `E_FLASH_TMO;
			hit = 1'b1;
		end

		// payload byte counting; a byte that comes with the last strobe still counts
		if (cmd_i.byte_vld && !cmd_i.byte_is_op) begin
			pcnt_now = st_r.pcnt + 16'h0001;
		end
		if (cmd_i.start) begin
			st_nxt.pcnt = 16'h0000;
		end else begin
			st_nxt.pcnt = pcnt_now;
		end
		if (cmd_i.byte_vld && cmd_i.byte_is_op != cmd_i.want_op) begin
			c = `E_CMD_TYPE;
			hit = 1'b1;
		end

		if (cmd_i.last) begin
			if (cmd_i.len_given && cmd_i.len_decl != pcnt_now) begin
				c = `E_PAY_SIZE;
				hit = 1'b1;
			end
			if (!cmd_i.crc_ok) begin
				c = `E_CMD_CRC;
				hit = 1'b1;
			end
			if (cmd_i.sig_req && !cmd_i.sig_ok) begin
				c = `E_SIGNATURE;
				hit = 1'b1;
			end
			// prefetch naming a write or no op-code
			if (boot_mode_i && cmd_i.is_pf && (cmd_i.pf_is_wr || cmd_i.pf_no_op)) begin
				c = `E_CMD_FORMAT;
				hit = 1'b1;
			end
			if (boot_mode_i && cmd_i.is_fwr && !cmd_i.len_given) begin
				c = `E_CMD_FORMAT;
				hit = 1'b1;
			end
			if (!cmd_i.op_known) begin
				c = `E_OPCODE;
				hit = 1'b1;
			end
			if (!cmd_i.hdr_ok) begin
				c = `E_HDR_FMT;
				hit = 1'b1;
			end
			// clear leaves the slot contents; pointer, count and last code restart
			// signed clear of record
			if (cmd_i.is_clear && cmd_i.sig_ok && cmd_i.hdr_ok && cmd_i.crc_ok) begin
				do_clear = 1'b1;
			end
		end

		// the refused command's later strobes are still checked
		// reject when queue full
		if (cmd_i.start && q_full_i) begin
			c = `E_QUEUE_FULL;
			hit = 1'b1;
			st_nxt.rej = 1'b1;
		end

		// buffers
		// transmit buffer overflow
		if (buf_i.tx_push && buf_i.tx_full) begin
			c = `E_TX_OVERFLOW;
			hit = 1'b1;
		end
		if (buf_i.load) begin
			if (st_r.pend) begin
				c = `E_RX_OVERFLOW;
				hit = 1'b1;
			end
			st_nxt.pend = 1'b1;
			st_nxt.rlen = buf_i.len;
		end

		// read-fetch and status transactions
		case (st_r.xs)
			XS_IDLE: begin
				if (xfer_i.start) begin
					st_nxt.xcnt = 16'h0000;
					if (xfer_i.kind == XK_STAT) begin
						st_nxt.xs = XS_STAT;
					end else if (st_r.pend) begin
						st_nxt.xs = XS_FETCH;
					end else begin
						c = `E_FETCH_NO_DATA;
						hit = 1'b1;
					end
				end
			end
			XS_FETCH: begin
				// a second start while open is ignored
				// a byte may ride on the stop strobe; it counts towards the length
				if (xfer_i.byte_vld && !xcnt_nx[16]) begin
					xcnt_now = xcnt_nx;
				end
				st_nxt.xcnt = xcnt_now[15:0];
				full_len = {1'b0, `HDR_BYTES} + {1'b0, st_r.rlen};
				if (xfer_i.crc_bad) begin
					c = `E_FETCH_CRC;
					hit = 1'b1;
				end
				if (xfer_i.stop) begin
					st_nxt.xs = XS_IDLE;
					if (xcnt_now < {1'b0, `HDR_BYTES}) begin
						c = `E_FETCH_HDR_EARLY;
						hit = 1'b1;
					end else if (xcnt_now < full_len) begin
						c = `E_FETCH_RSP_EARLY;
						hit = 1'b1;
					end else if (xcnt_now > full_len) begin
						c = `E_FETCH_LATE;
						hit = 1'b1;
					end
					// payload fully sent, response consumed; a new load keeps it pending
					if (xcnt_now >= full_len && !buf_i.load) begin
						st_nxt.pend = 1'b0;
					end
				end
			end
			XS_STAT: begin
				if (xfer_i.byte_vld && !xcnt_nx[16]) begin
					xcnt_now = xcnt_nx;
				end
				st_nxt.xcnt = xcnt_now[15:0];
				// status answers a fixed length, whatever is pending
				full_len = {1'b0, `HDR_BYTES} + {1'b0, `STAT_RSP_BYTES};
				if (xfer_i.crc_bad) begin
					c = `E_STAT_CRC;
					hit = 1'b1;
				end
				if (xfer_i.stop) begin
					st_nxt.xs = XS_IDLE;
					if (xcnt_now < {1'b0, `HDR_BYTES}) begin
						c = `E_STAT_HDR_EARLY;
						hit = 1'b1;
					end else if (xcnt_now < full_len) begin
						c = `E_STAT_RSP_EARLY;
						hit = 1'b1;
					end else if (xcnt_now > full_len) begin
						c = `E_STAT_LATE;
						hit = 1'b1;
					end
				end
			end
			default: begin
				st_nxt.xs = XS_IDLE;
			end
		endcase

		// error record, set wins over clear
		if (do_clear) begin
			st_nxt.cnt = 8'h00;
			st_nxt.wptr = 4'h0;
			st_nxt.last_code = 8'h00;
			rec_waddr = '0;
		end
		if (hit) begin
			st_nxt.err = 1'b1;
			st_nxt.code = c;
			st_nxt.last_code = c;
			// count saturates so a flood of errors never reads as none
			if (st_nxt.cnt != 8'hff) begin
				st_nxt.cnt = st_nxt.cnt + 8'h01;
			end
			// slots wrap; the oldest entries are overwritten first
			st_nxt.wptr = st_nxt.wptr + 4'h1;
		end
		rec_we = hit;
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// record writes land at the slot the pointer held before the error, or at slot 0 when a clear comes in the same cycle
	err_record_mem u_rec (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.we_i(rec_we),
		.waddr_i(rec_waddr),
		.wdata_i(c),
		.raddr_i(rec_idx_i),
		.rdata_o(rec_data_o)
	);

	assign err_pulse_o = st_r.err;
	assign err_code_o = st_r.code;
	assign last_code_o = st_r.last_code;
	assign err_cnt_o = st_r.cnt;
	assign cmd_reject_o = st_r.rej;
	assign rd_pending_o = st_r.pend;
endmodule
`default_nettype wire

// File: hdl/hce_consts.svh
// constants of the host command error classifier
`ifndef HCE_CONSTS_SVH
`define HCE_CONSTS_SVH
`define E_OUT_OF_RANGE 8'h03
`define E_ID_READ 8'h04
`define E_FLASH_BUSY 8'h05
`define E_CMD_TYPE 8'h0a
`define E_CMD_FORMAT 8'h0b
`define E_WR_SEQ 8'h0d
`define E_OPCODE 8'h0f
`define E_SIGNATURE 8'h10
`define E_CMD_CRC 8'h12
`define E_PAY_SIZE 8'h13
`define E_QUEUE_FULL 8'h16
`define E_NO_DEVICE 8'h1a
`define E_HDR_FMT 8'h46
`define E_FETCH_CRC 8'h47
`define E_FETCH_HDR_EARLY 8'h48
`define E_FETCH_RSP_EARLY 8'h49
`define E_FETCH_LATE 8'h4a
`define E_FETCH_NO_DATA 8'h4b
`define E_RX_OVERFLOW 8'h4c
`define E_STAT_CRC 8'h4e
`define E_STAT_HDR_EARLY 8'h4f
`define E_STAT_RSP_EARLY 8'h50
`define E_STAT_LATE 8'h51
`define E_TX_OVERFLOW 8'h52
`define E_FLASH_TMO 8'h7b
`define E_BOOT_LOAD_CRC 8'h83
`define E_MAIN_LOAD_CRC 8'h84
`define E_MAIN_RAM_CRC 8'h85
`define E_VERIFY_CRC 8'h86
`define FLASH_CAP_BYTES 32'h0100_0000
`define HDR_BYTES 16'h0004
`define STAT_RSP_BYTES 16'h0004
`define REC_AW 4
`define REC_DEPTH 16
`endif

// File: hdl/hce_pkg.sv
// types of the host command error classifier
package hce_pkg;
	typedef enum logic [1:0] {FOP_RD, FOP_ER, FOP_WR} flash_op_e;
	typedef enum logic [1:0] {XS_IDLE, XS_FETCH, XS_STAT} xfer_e;
	typedef enum logic {XK_FETCH, XK_STAT} xkind_e;
	typedef struct packed {
		logic req;
		flash_op_e op;
		logic busy;
		logic present;
		logic erased;
		logic [31:0] size;
		logic tmo;
	} flash_ev_s;
	typedef struct packed {
		logic id_done;
		logic id_ok;
		logic dev_found;
		logic dev_known;
		logic id_tmo;
		logic crc_boot;
		logic crc_main;
		logic crc_ram;
		logic crc_verify;
	} boot_ev_s;
	typedef struct packed {
		logic start;
		logic byte_vld;
		logic byte_is_op;
		logic want_op;
		logic last;
		logic op_known;
		logic hdr_ok;
		logic crc_ok;
		logic sig_req;
		logic sig_ok;
		logic is_clear;
		logic is_pf;
		logic pf_is_wr;
		logic pf_no_op;
		logic is_fwr;
		logic len_given;
		logic [15:0] len_decl;
	} cmd_ev_s;
	typedef struct packed {
		logic start;
		xkind_e kind;
		logic byte_vld;
		logic crc_bad;
		logic stop;
	} xfer_ev_s;
	typedef struct packed {
		logic load;
		logic [15:0] len;
		logic tx_push;
		logic tx_full;
	} buf_ev_s;
	typedef struct packed {
		logic [15:0][7:0] m;
		logic [7:0] rd;
	} rec_mem_s;
	typedef struct packed {
		xfer_e xs;
		logic [15:0] xcnt;
		logic [15:0] rlen;
		logic pend;
		logic [15:0] pcnt;
		logic [3:0] wptr;
		logic [7:0] cnt;
		logic [7:0] code;
		logic [7:0] last_code;
		logic err;
		logic rej;
	} cls_st_s;
endpackage

// File: hdl/err_record_mem.sv
// error record memory with registered read port
`timescale 1ns/1ps
`default_nettype none
`include "hce_consts.svh"
module err_record_mem
	import hce_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// write port
	input wire logic we_i,
	input wire logic [`REC_AW-1:0] waddr_i,
	input wire logic [7:0] wdata_i,
	// read port
	input wire logic [`REC_AW-1:0] raddr_i,
	output logic [7:0] rdata_o
);
	rec_mem_s st_r;
	rec_mem_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.rd = st_r.m[raddr_i];
		if (we_i) begin
			st_nxt.m[waddr_i] = wdata_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata_o = st_r.rd;
endmodule
`default_nettype wire

// File: sim/hce_props.sv
// assertions on the error classifier ports
`timescale 1ns/1ps
`default_nettype none
module hce_props
	import hce_pkg::*;
(
	// watched inputs
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire flash_ev_s flash_i,
	input wire cmd_ev_s cmd_i,
	input wire logic q_full_i,
	input wire xfer_ev_s xfer_i,
	input wire buf_ev_s buf_i,
	// watched outputs
	input wire logic err_pulse_o,
	input wire logic [7:0] err_code_o,
	input wire logic [7:0] last_code_o,
	input wire logic [7:0] err_cnt_o,
	input wire logic cmd_reject_o,
	input wire logic rd_pending_o
);
	logic lq;
	// link and buffer events outrank the rest
	assign lq = !(xfer_i.start || xfer_i.stop || xfer_i.crc_bad || buf_i.load || buf_i.tx_push);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	a_flash_busy: assert property (flash_i.req && flash_i.busy && !flash_i.tmo && !cmd_i.start
		&& !cmd_i.last && !cmd_i.byte_vld && lq |=> err_pulse_o && err_code_o == 8'h05) else $error("no 05");
	a_bad_opcode: assert property (cmd_i.last && cmd_i.hdr_ok && !cmd_i.op_known && !cmd_i.start && lq
		|=> err_code_o == 8'h0f) else $error("no 0f");
	a_bad_header: assert property (cmd_i.last && !cmd_i.hdr_ok && !cmd_i.start && lq
		|=> err_code_o == 8'h46) else $error("no 46");
	a_reject_now: assert property (cmd_i.start && q_full_i |=> cmd_reject_o) else $error("no reject");
	a_reject_cause: assert property (cmd_reject_o |-> $past(cmd_i.start && q_full_i)) else $error("bad reject");
	a_tx_full: assert property (buf_i.tx_push && buf_i.tx_full && !buf_i.load && !xfer_i.start
		&& !xfer_i.stop && !xfer_i.crc_bad |=> err_code_o == 8'h52) else $error("no 52");
	a_rx_over: assert property (buf_i.load && rd_pending_o && !xfer_i.start && !xfer_i.stop
		&& !xfer_i.crc_bad |=> err_code_o == 8'h4c) else $error("no 4c");
	a_count_step: assert property (err_cnt_o != $past(err_cnt_o) && err_cnt_o != 8'h00 |-> err_pulse_o)
		else $error("count moved");
	a_last_code: assert property (err_pulse_o |-> last_code_o == err_code_o) else $error("last code");
endmodule
bind host_cmd_error_classifier hce_props PROPS (.mclk_i(mclk_i), .rst_i(rst_i), .flash_i(flash_i),
	.cmd_i(cmd_i), .q_full_i(q_full_i), .xfer_i(xfer_i), .buf_i(buf_i), .err_pulse_o(err_pulse_o),
	.err_code_o(err_code_o), .last_code_o(last_code_o), .err_cnt_o(err_cnt_o),
	.cmd_reject_o(cmd_reject_o), .rd_pending_o(rd_pending_o));
`default_nettype wire

// File: sim/host_link_model.sv
// host side model of framed link transactions
`timescale 1ns/1ps
`default_nettype none
module host_link_model
	import hce_pkg::*;
(
	// clock
	input wire logic mclk_i,
	// transaction events
	output var xfer_ev_s xfer_o
);
	initial xfer_o = '0;
	task automatic run(input xkind_e k, input int n, input bit bad, input bit tail = 1'b0);
		@(negedge mclk_i);
		xfer_o = '{kind: k, start: 1'b1, default: '0};
		for (int i = 0; i < n; i++) begin
			@(negedge mclk_i);
			xfer_o = '{kind: k, byte_vld: 1'b1, crc_bad: bad && i == 0, default: '0};
		end
		@(negedge mclk_i);
		xfer_o = '{kind: k, stop: 1'b1, byte_vld: tail, default: '0};
		@(negedge mclk_i);
		xfer_o = '{kind: k, default: '0};
	endtask
endmodule
`default_nettype wire

// File: sim/host_cmd_error_classifier_tb_top.sv
// self-checking bench for the error classifier
`timescale 1ns/1ps
`default_nettype none
module host_cmd_error_classifier_tb_top
	import hce_pkg::*;
();
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic boot_mode_i = 1'b1;
	logic q_full_i = 1'b0;
	logic [3:0] rec_idx_i = 4'h0;
	flash_ev_s flash_i = '0;
	boot_ev_s boot_i = '0;
	cmd_ev_s cmd_i = '0;
	buf_ev_s buf_i = '0;
	xfer_ev_s xfer_i;
	logic err_pulse_o, cmd_reject_o, rd_pending_o;
	logic [7:0] err_code_o, last_code_o, err_cnt_o, rec_data_o;
	int err_count = 0;
	int checks = 0;
	int cyc = 0;
	always #2 mclk_i = ~mclk_i;
	host_link_model HOST (.mclk_i(mclk_i), .xfer_o(xfer_i));
	host_cmd_error_classifier DUT (.mclk_i(mclk_i), .rst_i(rst_i), .boot_mode_i(boot_mode_i), .flash_i(flash_i),
		.boot_i(boot_i), .cmd_i(cmd_i), .q_full_i(q_full_i), .xfer_i(xfer_i), .buf_i(buf_i), .rec_idx_i(rec_idx_i),
		.err_pulse_o(err_pulse_o), .err_code_o(err_code_o), .last_code_o(last_code_o), .err_cnt_o(err_cnt_o),
		.rec_data_o(rec_data_o), .cmd_reject_o(cmd_reject_o), .rd_pending_o(rd_pending_o));
	task automatic test_done;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// a hang ends the run as a failure
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_count++;
			test_done();
		end
	end
	// event set at this falling edge shows at the next one
	task automatic hit(input logic p, input logic [7:0] code);
		@(negedge mclk_i);
		chk("pulse", {7'h00, err_pulse_o}, {7'h00, p});
		chk("code", err_code_o, code);
	endtask
	task automatic fl(input flash_op_e op, input logic [3:0] f, input logic [31:0] sz,
		input logic p, input logic [7:0] c);
		flash_i = '{req: 1'b1, op: op, busy: f[3], present: f[2], erased: f[1], size: sz, tmo: f[0]};
		hit(p, c);
	endtask
	task automatic t_flash;
		fl(FOP_WR, 4'h6, 32'h0100_0001, 1'b1, 8'h03);
		fl(FOP_WR, 4'h6, 32'h0100_0000, 1'b0, 8'h03);
		fl(FOP_WR, 4'h4, 32'h0000_0010, 1'b1, 8'h0d);
		fl(FOP_ER, 4'h0, 32'h0000_0000, 1'b1, 8'h1a);
		fl(FOP_RD, 4'he, 32'h0000_0000, 1'b1, 8'h05);
		fl(FOP_WR, 4'h7, 32'h0000_0000, 1'b1, 8'h7b);
		flash_i = '0;
	endtask
	task automatic t_boot;
		logic [8:0] ev [8] = '{9'h100, 9'h180, 9'h1c0, 9'h010, 9'h008, 9'h004, 9'h002, 9'h001};
		logic [7:0] code [8] = '{8'h04, 8'h1a, 8'h1a, 8'h7b, 8'h83, 8'h84, 8'h85, 8'h86};
		for (int i = 0; i < 8; i++) begin
			boot_i = boot_ev_s'(ev[i]);
			hit(1'b1, code[i]);
		end
		boot_i = '0;
	endtask
	task automatic cm(input logic [6:0] f, input logic p, input logic [7:0] code);
		cmd_i = '{start: 1'b1, default: '0};
		@(negedge mclk_i);
		cmd_i = '{last: 1'b1, crc_ok: !f[0], op_known: !f[1], hdr_ok: !f[2], sig_req: f[3] | f[6], is_pf: f[4],
			pf_is_wr: f[4], len_given: 1'b1, len_decl: {15'h0000, f[5]}, sig_ok: f[6], is_clear: f[6], default: '0};
		hit(p, code);
	endtask
	task automatic t_cmd;
		cm(7'h01, 1'b1, 8'h12);
		cm(7'h02, 1'b1, 8'h0f);
		cm(7'h04, 1'b1, 8'h46);
		cm(7'h08, 1'b1, 8'h10);
		cm(7'h10, 1'b1, 8'h0b);
		cmd_i = '{last: 1'b1, crc_ok: 1'b1, op_known: 1'b1, hdr_ok: 1'b1, is_pf: 1'b1, pf_no_op: 1'b1, default: '0};
		hit(1'b1, 8'h0b);
		cmd_i = '{last: 1'b1, crc_ok: 1'b1, op_known: 1'b1, hdr_ok: 1'b1, is_fwr: 1'b1, default: '0};
		hit(1'b1, 8'h0b);
		boot_mode_i = 1'b0;
		cm(7'h10, 1'b0, 8'h0b);
		boot_mode_i = 1'b1;
		cm(7'h20, 1'b1, 8'h13);
		cmd_i = '{last: 1'b1, byte_vld: 1'b1, crc_ok: 1'b1, op_known: 1'b1, hdr_ok: 1'b1, len_given: 1'b1,
			len_decl: 16'h0001, default: '0};
		hit(1'b0, 8'h13);
		cm(7'h40, 1'b0, 8'h13);
		chk("count", err_cnt_o, 8'h00);
		chk("last", last_code_o, 8'h00);
		cm(7'h01, 1'b1, 8'h12);
		chk("count", err_cnt_o, 8'h01);
		chk("last", last_code_o, 8'h12);
		cmd_i = '{byte_vld: 1'b1, want_op: 1'b1, default: '0};
		hit(1'b1, 8'h0a);
		chk("slot", rec_data_o, 8'h12);
		q_full_i = 1'b1;
		cmd_i = '{start: 1'b1, default: '0};
		hit(1'b1, 8'h16);
		chk("reject", {7'h00, cmd_reject_o}, 8'h01);
		q_full_i = 1'b0;
		cmd_i = '0;
	endtask
	task automatic t_link;
		int n [10] = '{3, 6, 9, 8, 8, 3, 5, 7, 6, 6};
		logic [7:0] code [10] = '{8'h4f, 8'h50, 8'h51, 8'h4e, 8'h4e, 8'h48, 8'h49, 8'h4a, 8'h47, 8'h47};
		for (int i = 0; i < 10; i++) begin
			if (i > 4 && rd_pending_o !== 1'b1) begin
				buf_i = '{load: 1'b1, len: 16'h0002, default: '0};
				@(negedge mclk_i);
				buf_i = '0;
			end
			HOST.run(i > 4 ? XK_FETCH : XK_STAT, n[i], i == 3 || i == 8);
			chk("link code", err_code_o, code[i]);
		end
		buf_i = '{load: 1'b1, len: 16'h0002, default: '0};
		@(negedge mclk_i);
		buf_i = '0;
		// the sixth byte rides on the stop strobe
		HOST.run(XK_FETCH, 5, 1'b0, 1'b1);
		chk("tail code", err_code_o, 8'h47);
		chk("pending", {7'h00, rd_pending_o}, 8'h00);
		HOST.run(XK_FETCH, 0, 1'b0);
		chk("no data", err_code_o, 8'h4b);
		buf_i = '{load: 1'b1, len: 16'h0002, default: '0};
		hit(1'b0, 8'h4b);
		hit(1'b1, 8'h4c);
		buf_i = '{tx_push: 1'b1, tx_full: 1'b1, default: '0};
		hit(1'b1, 8'h52);
		buf_i = '0;
	endtask
	initial begin
		repeat (3) @(negedge mclk_i);
		rst_i = 1'b0;
		chk("count", err_cnt_o, 8'h00);
		t_flash();
		t_boot();
		t_cmd();
		t_link();
		test_done();
	end
endmodule
`default_nettype wire
